// ---- ebc_pkg.sv ----
package ebc_pkg;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int AREA_N = 4;
  localparam int AREA_W = 2;

  // multiplexed lane windows
  localparam int MUX16_LSB = 1;
  localparam int MUX8_LSB  = 0;
  localparam int LANE_W    = 8;

  // cycle timing in ref_clk cycles
  localparam int ALE_CYCLES = 1;
  localparam int STB_CYCLES = 2;

  localparam logic [3:0] AREA_NONE = 4'hf;

  typedef enum logic [4:0] {
    EBC_IDLE   = 5'h01,
    EBC_ADDR   = 5'h02,
    EBC_STROBE = 5'h04,
    EBC_END    = 5'h08,
    EBC_HOLD   = 5'h10
  } ebc_state_t;

  typedef struct packed {
    logic                write;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic [AREA_W-1:0]   area;
  } ebc_req_t;

  typedef struct packed {
    logic low_byte_write_strobe_n;
    logic high_byte_write_strobe_n;
    logic rd_n;
    logic upper_byte_enable_n;
    logic wr_n;
  } ebc_strobe_t;

endpackage : ebc_pkg

// ---- ebc_strobe_dec.sv ----
`timescale 1ns/1ps
// strobe pattern for one access
module ebc_strobe_dec (
  input  wire logic                active,
  input  wire logic                write,
  input  wire logic                odd,
  input  wire logic                single_wr_mode,
  input  wire logic                bus8,
  output      ebc_pkg::ebc_strobe_t stb
);
  always_comb begin
    stb = '{default: 1'b1};
    if (active) begin
      if (!write) begin
        stb.rd_n = 1'b0;
      end else if (single_wr_mode) begin
        stb.wr_n = 1'b0;
      end else begin
        stb.low_byte_write_strobe_n  = odd & !bus8;
        stb.high_byte_write_strobe_n = !odd;
      end
      if (single_wr_mode) begin
        stb.upper_byte_enable_n = !odd;
      end
    end
  end
endmodule : ebc_strobe_dec

// ---- ebc_bus_ctrl.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - 16-bit mux: lanes carry A1..A8
// - one of four active-low area selects low per access
// - low strobes; scheme chosen by configuration
// - split scheme: low write for even
// - split scheme: high write for odd
// - read strobe low; memory drives lanes
// - single scheme: one write strobe plus read
// - single scheme: upper enable low when odd
// - address latch strobe output
// - bus request low holds the device
// - bus grant low throughout hold
// - wait request low keeps wait state
// - 8-bit mux: lanes carry A0..A7
// - separate bus: 20-bit dedicated address
module ebc_bus_ctrl (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        single_wr_mode,
  input  wire logic                        bus8,
  input  wire logic                        mux_mode,
  input  wire logic                        req_valid,
  output      logic                        req_ready,
  input  wire ebc_pkg::ebc_req_t           req,
  output      logic                        rsp_valid,
  output      logic [ebc_pkg::DATA_W-1:0]  rsp_rdata,
  input  wire logic                        bus_req_n,
  input  wire logic                        wait_req_n,
  output      logic                        bus_grant_out,
  output      logic [ebc_pkg::AREA_N-1:0]  area_select_lines,
  output      logic                        ale,
  output      logic                        low_byte_write_strobe,
  output      logic                        high_byte_write_strobe,
  output      logic                        rd_n,
  output      logic                        wr_n,
  output      logic                        upper_byte_enable,
  output      logic                        strobe_oe,
  output      logic [ebc_pkg::ADDR_W-1:0]  addr_o,
  output      logic                        addr_oe,
  input  wire logic [ebc_pkg::DATA_W-1:0]  data_i,
  output      logic [ebc_pkg::DATA_W-1:0]  data_o,
  output      logic                        data_oe
);
  localparam int CW = 2;
  localparam logic [CW-1:0] STB_LAST = CW'(ebc_pkg::STB_CYCLES - 1);

  ebc_pkg::ebc_state_t state_q, state_d;
  ebc_pkg::ebc_req_t   cur_q, cur_d;
  logic [CW-1:0]       cnt_q, cnt_d;
  logic [ebc_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic                done_q, done_d;
  ebc_pkg::ebc_strobe_t stb;
  logic                 stb_act;

  always_comb begin
    state_d = state_q;
    cur_d   = cur_q;
    cnt_d   = cnt_q;
    rdata_d = rdata_q;
    done_d  = 1'b0;
    case (state_q)
      ebc_pkg::EBC_IDLE: begin
        if (!bus_req_n) begin
          state_d = ebc_pkg::EBC_HOLD;
        end else if (req_valid) begin
          cur_d   = req;
          cnt_d   = '0;
          state_d = ebc_pkg::EBC_ADDR;
        end
      end
      ebc_pkg::EBC_ADDR: begin
        state_d = ebc_pkg::EBC_STROBE;
      end
      ebc_pkg::EBC_STROBE: begin
        if (cnt_q != STB_LAST) begin
          cnt_d = cnt_q + 1'b1;
        end else if (wait_req_n) begin
          if (!cur_q.write) begin
            rdata_d = data_i;
          end
          done_d  = 1'b1;
          state_d = ebc_pkg::EBC_END;
        end
      end
      ebc_pkg::EBC_END: begin
        state_d = ebc_pkg::EBC_IDLE;
      end
      ebc_pkg::EBC_HOLD: begin
        if (bus_req_n) begin
          state_d = ebc_pkg::EBC_IDLE;
        end
      end
      default: state_d = ebc_pkg::EBC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ebc_pkg::EBC_IDLE;
      cur_q   <= '0;
      cnt_q   <= '0;
      rdata_q <= '0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cur_q   <= cur_d;
      cnt_q   <= cnt_d;
      rdata_q <= rdata_d;
      done_q  <= done_d;
    end
  end

  assign req_ready = (state_q == ebc_pkg::EBC_IDLE) && bus_req_n;
  assign rsp_valid = done_q;
  assign rsp_rdata = rdata_q;

  assign stb_act = (state_q == ebc_pkg::EBC_STROBE);

  ebc_strobe_dec u_dec (
    .active         (stb_act),
    .write          (cur_q.write),
    .odd            (cur_q.addr[0]),
    .single_wr_mode (single_wr_mode),
    .bus8           (bus8),
    .stb            (stb)
  );

  logic in_cycle;
  logic [ebc_pkg::LANE_W-1:0] lane_addr;
  assign in_cycle = (state_q == ebc_pkg::EBC_ADDR) || stb_act ||
                    (state_q == ebc_pkg::EBC_END);

  always_comb begin
    if (bus8) begin
      lane_addr = cur_q.addr[ebc_pkg::MUX8_LSB +: ebc_pkg::LANE_W];
    end else begin
      lane_addr = cur_q.addr[ebc_pkg::MUX16_LSB +: ebc_pkg::LANE_W];
    end
  end

  always_comb begin
    area_select_lines = ebc_pkg::AREA_NONE;
    if (in_cycle) begin
      area_select_lines[cur_q.area] = 1'b0;
    end
  end

  assign ale                    = (state_q == ebc_pkg::EBC_ADDR);
  assign low_byte_write_strobe  = stb.low_byte_write_strobe_n;
  assign high_byte_write_strobe = stb.high_byte_write_strobe_n;
  assign rd_n                   = stb.rd_n;
  assign wr_n                   = stb.wr_n;
  assign upper_byte_enable      = stb.upper_byte_enable_n;
  assign bus_grant_out          = (state_q != ebc_pkg::EBC_HOLD);
  assign strobe_oe              = (state_q != ebc_pkg::EBC_HOLD);
  assign addr_oe                = (state_q != ebc_pkg::EBC_HOLD);
  assign addr_o                 = cur_q.addr;

  always_comb begin
    data_o  = cur_q.wdata;
    data_oe = 1'b0;
    if (state_q == ebc_pkg::EBC_ADDR && mux_mode) begin
      data_o[ebc_pkg::LANE_W-1:0] = lane_addr;
      data_oe = 1'b1;
    end else if (stb_act && cur_q.write) begin
      data_oe = 1'b1;
    end
  end

  property p_hold_grant;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_q == ebc_pkg::EBC_IDLE && !bus_req_n) |=> !bus_grant_out;
  endproperty
  a_hold_grant: assert property (p_hold_grant) else $error("no hold");

  property p_grant_release;
    @(posedge ref_clk) disable iff (!rst_n)
      !bus_grant_out |-> (!strobe_oe && !addr_oe && !data_oe && rd_n);
  endproperty
  a_grant_release: assert property (p_grant_release) else $error("hold drives");

  property p_grant_low;
    @(posedge ref_clk) disable iff (!rst_n)
      (!bus_grant_out && !bus_req_n) |=> !bus_grant_out;
  endproperty
  a_grant_low: assert property (p_grant_low) else $error("grant left");

  property p_wait_stable;
    @(posedge ref_clk) disable iff (!rst_n)
      (stb_act && cnt_q == STB_LAST && !wait_req_n) |=>
        (stb_act && $stable(area_select_lines) && $stable(addr_o));
  endproperty
  a_wait_stable: assert property (p_wait_stable) else $error("wait lost");

  property p_ale_then_strobe;
    @(posedge ref_clk) disable iff (!rst_n)
      ale |=> (stb_act && !ale) ##1 stb_act;
  endproperty
  a_ale_then_strobe: assert property (p_ale_then_strobe) else $error("ale seq");

  property p_cs_one;
    @(posedge ref_clk) disable iff (!rst_n)
      in_cycle |-> $onehot(~area_select_lines);
  endproperty
  a_cs_one: assert property (p_cs_one) else $error("area select");

  property p_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (stb_act && !cur_q.write) |-> (!rd_n && !data_oe && wr_n);
  endproperty
  a_read: assert property (p_read) else $error("read strobe");

  property p_split_even;
    @(posedge ref_clk) disable iff (!rst_n)
      (stb_act && cur_q.write && !single_wr_mode && !cur_q.addr[0]) |->
        (!low_byte_write_strobe && high_byte_write_strobe);
  endproperty
  a_split_even: assert property (p_split_even) else $error("even write");

  property p_split_odd;
    @(posedge ref_clk) disable iff (!rst_n)
      (stb_act && cur_q.write && !single_wr_mode && cur_q.addr[0]) |->
        !high_byte_write_strobe;
  endproperty
  a_split_odd: assert property (p_split_odd) else $error("odd write");

  property p_single;
    @(posedge ref_clk) disable iff (!rst_n)
      (stb_act && single_wr_mode) |->
        (upper_byte_enable == !cur_q.addr[0]) && (wr_n == !cur_q.write);
  endproperty
  a_single: assert property (p_single) else $error("single scheme");

  property p_mux_lanes;
    @(posedge ref_clk) disable iff (!rst_n)
      (ale && mux_mode && !bus8) |->
        data_o[ebc_pkg::LANE_W-1:0] == cur_q.addr[ebc_pkg::LANE_W:1];
  endproperty
  a_mux_lanes: assert property (p_mux_lanes) else $error("mux lanes");
endmodule : ebc_bus_ctrl

// ---- ebc_mem_model.sv ----
`timescale 1ns/1ps
// external memory plus alternate master
module ebc_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        ale,
  input  wire logic        b8,
  input  wire logic [19:0] addr_o,
  input  wire logic [3:0]  stb_n,
  input  wire logic [15:0] data_o,
  input  wire logic        stall,
  input  wire logic        hold,
  output      logic [15:0] data_i,
  output      logic        wait_req_n,
  output      logic        bus_req_n
);
  logic [15:0] mem [256];
  logic [15:0] last = 16'h0000;
  logic [8:0]  adr  = 9'h000;
  int          wcnt = 0;
  initial for (int i = 0; i < 256; i++) mem[i] = 16'(i * 257) ^ 16'ha5c3;
  assign bus_req_n  = ~hold;
  assign wait_req_n = (wcnt == 0);
  // released lanes show the inverse of the last value
  assign data_i     = stb_n[1] ? ~last : mem[adr[8:1]];
  always @(posedge ref_clk) begin
    if (!stb_n[1]) last <= mem[adr[8:1]];
    if (ale) adr <= addr_o[8:0];
    if (ale) wcnt <= stall ? 3 : 0;
    else if (wcnt > 0 && stb_n != 4'hf) wcnt <= wcnt - 1;
    if (!b8 && !adr[0] && (!stb_n[3] || !stb_n[0])) mem[adr[8:1]] <= data_o;
  end
endmodule : ebc_mem_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic              ref_clk = 1'b0;
  logic              rst_n, sw, b8, mux, req_valid, stall, hold;
  ebc_pkg::ebc_req_t req;
  logic              req_ready, rsp_valid, bus_grant_out, ale, lo_n, hi_n, rd_n, wr_n;
  logic              ube_n, strobe_oe, addr_oe, data_oe, wait_req_n, bus_req_n;
  logic [15:0]       rsp_rdata, data_o, data_i;
  logic [19:0]       addr_o;
  logic [3:0]        area_select_lines;
  logic [15:0]       bmem [256];
  logic [31:0]       seed = 32'h35;
  int                mismatches = 0;
  int                cmp_count = 0;
  always #20 ref_clk = ~ref_clk;
  ebc_bus_ctrl dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .single_wr_mode(sw), .bus8(b8), .mux_mode(mux),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .bus_req_n(bus_req_n), .wait_req_n(wait_req_n),
    .bus_grant_out(bus_grant_out), .area_select_lines(area_select_lines), .ale(ale),
    .low_byte_write_strobe(lo_n), .high_byte_write_strobe(hi_n), .rd_n(rd_n),
    .wr_n(wr_n), .upper_byte_enable(ube_n), .strobe_oe(strobe_oe), .addr_o(addr_o),
    .addr_oe(addr_oe), .data_i(data_i), .data_o(data_o), .data_oe(data_oe));
  ebc_mem_model mem_u (
    .ref_clk(ref_clk), .ale(ale), .b8(b8), .addr_o(addr_o),
    .stb_n({lo_n, hi_n, rd_n, wr_n}), .data_o(data_o), .stall(stall), .hold(hold),
    .data_i(data_i), .wait_req_n(wait_req_n), .bus_req_n(bus_req_n));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic give_verdict();
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [19:0] s, input logic [19:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic lim(input int n, input int m);
    if (n >= m) begin
      mismatches++;
      give_verdict();
    end
  endtask : lim
  task automatic xfer(input logic [31:0] r);
    int         n;
    int         s;
    logic [2:0] e;
    logic [2:0] v;
    n = 0;
    s = 0;
    stall = r[20];
    req = '{r[21], r[19:0], r[31:16], r[23:22]};
    e = sw ? {!req.write, req.write, !req.addr[0]}
           : {!(req.write && !req.addr[0]), !(req.write && req.addr[0]), req.write};
    req_valid = 1'b1;
    while (!req_ready && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    lim(n, 20);
    @(posedge ref_clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (!rsp_valid && n < 30) begin
      if (ale) chk(area_select_lines, 4'(~(4'h1 << req.area)));
      if (ale) chk(data_oe, mux);
      if (ale) chk(addr_o, req.addr);
      if (ale && mux) chk(data_o[7:0], b8 ? req.addr[7:0] : req.addr[8:1]);
      v = sw ? {wr_n, rd_n, ube_n} : {lo_n, hi_n, rd_n};
      if (!rd_n || (sw ? !wr_n : !(lo_n && hi_n))) begin
        chk(v, e);
        chk(data_oe, req.write);
        s++;
      end
      @(posedge ref_clk);
      #1;
      n++;
    end
    lim(n, 30);
    // a stalled access holds wait low for two extra strobe cycles
    chk(n, stall ? 5 : 3);
    chk(s, stall ? 4 : 2);
    if (!b8 && !req.addr[0] && req.write) bmem[req.addr[8:1]] = req.wdata;
    if (!req.write) chk(rsp_rdata, bmem[req.addr[8:1]]);
  endtask : xfer
  initial begin
    {rst_n, sw, b8, mux, req_valid, stall, hold} = 7'h00;
    req = '0;
    foreach (bmem[i]) bmem[i] = 16'(i * 257) ^ 16'ha5c3;
    for (int c = 0; c < 6; c++) begin
      // width and scheme change only under reset
      sw = c > 1;
      b8 = c > 3;
      mux = c[0];
      rst_n = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      chk({area_select_lines, bus_grant_out, rd_n, data_oe}, 7'h7e);
      repeat (16) xfer(xs());
      hold = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      chk({bus_grant_out, addr_oe, strobe_oe, req_ready}, 4'h0);
      hold = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(bus_grant_out, 1'b1);
    end
    give_verdict();
  end
endmodule : tb_top
